// ===== rtl/sq_clkgen.sv
// serial clock divider and edge generator
`timescale 1ns/100ps
module sq_clkgen (
	input  wire logic                     clk,
	input  wire logic                     arst_n,
	input  wire logic                     run,
	input  wire logic [sq_pkg::DIV_W-1:0] divider,
	output logic                          tick
);
	logic [sq_pkg::DIV_W-1:0] cnt_r;
	logic [sq_pkg::DIV_W-1:0] cnt_nxt;
	wire                      atEnd = (cnt_r + sq_pkg::DIV_ONE) >= divider;

	// divider of zero behaves as one so the clock never stalls
	assign cnt_nxt = (!run || atEnd) ? sq_pkg::DIV_RST
		: cnt_r + sq_pkg::DIV_ONE;
	assign tick = run && atEnd;

	// half period counter
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r <= sq_pkg::DIV_RST;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule

// ===== rtl/sq_pkg.sv
// package for the serial unit: constants, types and states
package sq_pkg;
	localparam int NUM_CS = 4;
	localparam int CS_W = 2;
	localparam int DATA_W = 16;
	localparam int DIV_W = 8;
	localparam int CNT_W = 5;
	localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
	localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
	localparam logic [CNT_W-1:0] BITS_PER_WORD = 5'h10;
	localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
	localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

	// per chip select configuration
	typedef struct packed {
		logic             polarity;
		logic             invertedPhaseSetting;
		logic             holdSelectAfterTransfer;
		logic [DIV_W-1:0] serialClockDivider;
	} sq_cscfg_t;

	localparam sq_cscfg_t CSCFG_RST = '{1'b0, 1'b0, 1'b0, DIV_RST};

	// mode register fields
	typedef struct packed {
		logic            master;
		logic            faultDetectOff;
		logic [CS_W-1:0] selectIndex;
	} sq_mode_t;

	localparam sq_mode_t MODE_RST = '{1'b0, 1'b0, 2'h0};

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SHIFT = 2'b01,
		ST_DONE  = 2'b11
	} sq_state_t;
endpackage

// ===== rtl/sq_spi_unit.sv
// serial peripheral unit with enable, reset and clock quirks
// Functional notes
// - with select 0 held after transfer and fault detect on, no transfer starts.
// - disabling leaves the transmit-empty flag as it was.
// - writes to the transmit word while disabled are dropped and never sent.
// - a write while disabled does not clear the transmit-empty flag.
// - dma writes after a disable keep being accepted and are lost.
// - in slave mode clearing the enable has no effect.
// - the soft reset bit resets the unit and stops a slave too.
// - mixed dividers of one and other with polarity 1, phase 0 give an extra pulse.
// - the fault-detect-off bit turns fault detection off.
`timescale 1ns/100ps
module sq_spi_unit (
	input  wire logic                         clk,
	input  wire logic                         arst_n,
	input  wire logic                         enableSet,
	input  wire logic                         enableClear,
	input  wire logic                         soft_reset_bit,
	input  wire logic                         modeWrite,
	input  wire sq_pkg::sq_mode_t             modeIn,
	input  wire logic                         cfgWrite,
	input  wire logic [sq_pkg::CS_W-1:0]      cfgIndex,
	input  wire sq_pkg::sq_cscfg_t            cfgIn,
	input  wire logic                         txWrite,
	input  wire logic [sq_pkg::DATA_W-1:0]    txData,
	input  wire logic                         dmaWrite,
	input  wire logic [sq_pkg::DATA_W-1:0]    dmaData,
	input  wire logic                         rxRead,
	input  wire logic                         miso,
	input  wire logic                         mosiIn,
	input  wire logic                         sckIn,
	input  wire logic                         selIn_n,
	output logic                              sck,
	output logic                              mosi,
	output logic [sq_pkg::NUM_CS-1:0]         sel_n,
	output logic                              misoOut,
	output logic                              misoOe_n,
	output logic                              enabled,
	output logic                              tx_holding_empty_flag,
	output logic                              rxFull,
	output logic [sq_pkg::DATA_W-1:0]         rxData,
	output logic                              modeFault,
	output logic                              dmaReady
);
	// ********************************************************
	// state
	// ********************************************************
	sq_pkg::sq_state_t               st_r, st_nxt;
	sq_pkg::sq_mode_t                mode_register_r;
	sq_pkg::sq_cscfg_t               select_config_register_r [sq_pkg::NUM_CS];
	logic                            en_r;
	logic                            txe_r;
	logic [sq_pkg::DATA_W-1:0]       transmit_word_register_r;
	logic [sq_pkg::DATA_W-1:0]       shift_r;
	logic [sq_pkg::CNT_W-1:0]        bits_r;
	logic                            sck_r;
	logic                            half_r;
	logic                            extra_r;
	logic                            fault_r;
	logic                            rxf_r;
	logic [sq_pkg::DATA_W-1:0]       rxd_r;
	logic                            sIn_r, sckPrev_r;
	logic                            tick;

	// ********************************************************
	// decode
	// ********************************************************
	sq_pkg::sq_cscfg_t curCfg;
	assign curCfg = select_config_register_r[mode_register_r.selectIndex];

	// a divider of zero runs at one, so it counts as one here too
	function automatic logic isDivOne(input sq_pkg::sq_cscfg_t c);
		isDivOne = (c.serialClockDivider <= sq_pkg::DIV_ONE);
	endfunction

	// mixed divider detection across all selects
	logic [sq_pkg::NUM_CS-1:0] oneVec;
	genvar gi;
	generate
		for (gi = 0; gi < sq_pkg::NUM_CS; gi++) begin : g_one
			assign oneVec[gi] = isDivOne(select_config_register_r[gi]);
		end
	endgenerate
	wire mixedDiv = (|oneVec) && !(&oneVec);
	wire quirkMode = mixedDiv && curCfg.polarity
		&& !curCfg.invertedPhaseSetting;

	wire faultOn  = !mode_register_r.faultDetectOff;
	wire hangCond = select_config_register_r[0].holdSelectAfterTransfer
		&& faultOn;
	wire anyWrite = txWrite || dmaWrite;
	wire [sq_pkg::DATA_W-1:0] wrData = txWrite ? txData : dmaData;
	wire acceptWr = anyWrite && en_r;
	wire startOk  = en_r && mode_register_r.master && !txe_r
		&& !hangCond && !fault_r;
	wire faultHit = mode_register_r.master && faultOn && !selIn_n;
	// slave keeps running after a clear
	wire enClr    = enableClear && mode_register_r.master;
	wire sckRise  = sckIn && !sckPrev_r;

	assign dmaReady = 1'b1;
	assign enabled = en_r;
	assign tx_holding_empty_flag = txe_r;
	assign rxFull = rxf_r;
	assign rxData = rxd_r;
	assign modeFault = fault_r;
	assign sck = sck_r;
	assign mosi = shift_r[sq_pkg::DATA_W-1];
	assign misoOut = shift_r[sq_pkg::DATA_W-1];
	assign misoOe_n = mode_register_r.master || selIn_n || !en_r;
	assign sel_n = (st_r == sq_pkg::ST_IDLE) ? '1
		: ~(sq_pkg::NUM_CS'(1) << mode_register_r.selectIndex);

	sq_clkgen u_clk (
		.clk     (clk),
		.arst_n  (arst_n),
		.run     (st_r == sq_pkg::ST_SHIFT),
		.divider (curCfg.serialClockDivider),
		.tick    (tick)
	);

	// ********************************************************
	// master sequencer
	// ********************************************************
	always_comb begin
		st_nxt = st_r;
		unique case (st_r)
			sq_pkg::ST_IDLE: if (startOk) st_nxt = sq_pkg::ST_SHIFT;
			sq_pkg::ST_SHIFT: if (tick && half_r
				&& bits_r == sq_pkg::BITS_PER_WORD - 5'h01)
				st_nxt = sq_pkg::ST_DONE;
			sq_pkg::ST_DONE: st_nxt = sq_pkg::ST_IDLE;
			default: st_nxt = sq_pkg::ST_IDLE;
		endcase
	end

	// control and config registers; soft reset restores all of it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_register_r <= sq_pkg::MODE_RST;
			en_r <= 1'b0;
			for (int i = 0; i < sq_pkg::NUM_CS; i++)
				select_config_register_r[i] <= sq_pkg::CSCFG_RST;
		end else if (soft_reset_bit) begin
			mode_register_r <= sq_pkg::MODE_RST;
			en_r <= 1'b0;
			for (int i = 0; i < sq_pkg::NUM_CS; i++)
				select_config_register_r[i] <= sq_pkg::CSCFG_RST;
		end else begin
			if (modeWrite) mode_register_r <= modeIn;
			if (cfgWrite) select_config_register_r[cfgIndex] <= cfgIn;
			if (enClr) en_r <= 1'b0;
			else if (enableSet) en_r <= 1'b1;
		end
	end

	// transmit holding word and its empty flag; disable never touches it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			txe_r <= 1'b1;
			transmit_word_register_r <= sq_pkg::DATA_ZERO;
		end else if (soft_reset_bit) begin
			txe_r <= 1'b1;
			transmit_word_register_r <= sq_pkg::DATA_ZERO;
		end else if (acceptWr) begin
			txe_r <= 1'b0;
			transmit_word_register_r <= wrData;
		end else if (st_r == sq_pkg::ST_IDLE && startOk) begin
			txe_r <= 1'b1;
		end
	end

	// shifter, serial clock and extra pulse quirk
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_r <= sq_pkg::ST_IDLE;
			shift_r <= sq_pkg::DATA_ZERO;
			bits_r <= sq_pkg::CNT_ZERO;
			sck_r <= 1'b0;
			half_r <= 1'b0;
			extra_r <= 1'b0;
			sIn_r <= 1'b0;
			sckPrev_r <= 1'b0;
		end else if (soft_reset_bit) begin
			st_r <= sq_pkg::ST_IDLE;
			shift_r <= sq_pkg::DATA_ZERO;
			bits_r <= sq_pkg::CNT_ZERO;
			sck_r <= 1'b0;
			half_r <= 1'b0;
			extra_r <= 1'b0;
			sIn_r <= 1'b0;
			sckPrev_r <= sckIn;
		end else begin
			st_r <= st_nxt;
			sckPrev_r <= sckIn;
			if (st_r == sq_pkg::ST_IDLE) begin
				sck_r <= curCfg.polarity;
				half_r <= 1'b0;
				bits_r <= sq_pkg::CNT_ZERO;
				extra_r <= quirkMode;
				if (startOk) shift_r <= transmit_word_register_r;
				else if (en_r && !mode_register_r.master
					&& !selIn_n && sckRise) // slave shift
					shift_r <= {shift_r[sq_pkg::DATA_W-2:0], mosiIn};
			end else if (st_r == sq_pkg::ST_SHIFT && tick) begin
				sck_r <= !sck_r;
				half_r <= !half_r;
				if (!half_r) sIn_r <= miso;
				else begin
					shift_r <= {shift_r[sq_pkg::DATA_W-2:0], sIn_r};
					bits_r <= bits_r + 5'h01;
				end
			end else if (st_r == sq_pkg::ST_DONE) begin
				// stray pulse: one more low phase before idle
				sck_r <= extra_r ? !curCfg.polarity : curCfg.polarity;
				extra_r <= 1'b0;
			end
		end
	end

	// receive holder and mode fault flag; set wins over clear
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rxf_r <= 1'b0;
			rxd_r <= sq_pkg::DATA_ZERO;
			fault_r <= 1'b0;
		end else if (soft_reset_bit) begin
			rxf_r <= 1'b0;
			rxd_r <= sq_pkg::DATA_ZERO;
			fault_r <= 1'b0;
		end else begin
			if (st_r == sq_pkg::ST_DONE) begin
				rxf_r <= 1'b1;
				rxd_r <= shift_r;
			end else if (rxRead) rxf_r <= 1'b0;
			if (faultHit) fault_r <= 1'b1;
			else if (modeWrite) fault_r <= 1'b0;
		end
	end

	// ********************************************************
	// checks
	// ********************************************************
	a_hang_no_start: assert property (@(posedge clk) disable iff (!arst_n)
		hangCond && st_r == sq_pkg::ST_IDLE |=> st_r == sq_pkg::ST_IDLE)
		else $error("transfer started while hang condition");
	a_disable_keeps_flag: assert property (@(posedge clk)
		disable iff (!arst_n) enableClear && !anyWrite && !soft_reset_bit
		&& !(st_r == sq_pkg::ST_IDLE && startOk)
		|=> $stable(txe_r))
		else $error("disable changed empty flag");
	a_drop_write: assert property (@(posedge clk) disable iff (!arst_n)
		anyWrite && !en_r && !soft_reset_bit
		|=> $stable(transmit_word_register_r))
		else $error("write stored while disabled");
	a_flag_stays: assert property (@(posedge clk) disable iff (!arst_n)
		txWrite && !en_r && txe_r && !soft_reset_bit |=> txe_r)
		else $error("empty flag cleared while disabled");
	a_dma_ready: assert property (@(posedge clk) disable iff (!arst_n)
		!en_r && dmaWrite && !txWrite && !soft_reset_bit
		|-> dmaReady ##1 $stable(txe_r))
		else $error("dma stalled after disable");
	a_slave_stays: assert property (@(posedge clk) disable iff (!arst_n)
		en_r && !mode_register_r.master && !soft_reset_bit
		&& !modeWrite |=> en_r)
		else $error("slave unit disabled");
	a_soft_reset: assert property (@(posedge clk) disable iff (!arst_n)
		soft_reset_bit |=> !en_r && txe_r && !rxf_r
		&& st_r == sq_pkg::ST_IDLE
		&& mode_register_r == sq_pkg::MODE_RST)
		else $error("soft reset incomplete");
	a_fault_off: assert property (@(posedge clk) disable iff (!arst_n)
		mode_register_r.faultDetectOff && !fault_r |=> !fault_r
		|| $past(modeWrite))
		else $error("fault set while detection off");
	// stray pulse: one cycle away from the idle level, then back
	sequence s_stray_pulse;
		sck_r != curCfg.polarity ##1 sck_r == curCfg.polarity;
	endsequence
	a_extra_pulse: assert property (@(posedge clk) disable iff (!arst_n)
		st_r == sq_pkg::ST_DONE && extra_r && !soft_reset_bit
		|=> s_stray_pulse)
		else $error("extra pulse missing");
endmodule

// ===== sim/sq_slave_model.sv
// serial slave model seen from the unit's master pins
`timescale 1ns/100ps
module sq_slave_model #(
	parameter logic [15:0] REPLY = 16'ha5c3
) (
	input  wire logic        sck,
	input  wire logic        mosi,
	input  wire logic        selN,
	output logic             miso,
	output logic [15:0]      rxWord
);
	// ****************************************
	// shift logic, msb first
	// ****************************************
	logic [15:0] shiftOut;

	initial begin
		miso = 1'b0;
		rxWord = 16'h0000;
		shiftOut = REPLY;
	end

	// first bit is presented as soon as the select drops
	always @(negedge selN) begin
		shiftOut = REPLY;
		miso = REPLY[15];
	end

	// capture on the rising edge, change on the falling edge
	always @(posedge sck) begin
		if (!selN) begin
			rxWord = {rxWord[14:0], mosi};
		end
	end

	always @(negedge sck) begin
		if (!selN) begin
			shiftOut = shiftOut << 1;
			miso = shiftOut[15];
		end
	end

	// released line is not held: show the inverse so stale data cannot pass
	always @(posedge selN) begin
		miso = ~miso;
	end
endmodule

// ===== sim/tb_sq_spi_unit.sv
// self-checking bench for the serial unit
`timescale 1ns/100ps
module tb_sq_spi_unit;
	// ****************************************
	// signals, design and partner
	// ****************************************
	logic              clk = 0;
	logic              arst_n = 0;
	logic              enSet = 0;
	logic              enClr = 0;
	logic              softReset = 0;
	logic              rxRead = 0;
	logic              modeWrite = 0;
	logic              cfgWrite = 0;
	logic              txWrite = 0;
	logic              dmaWrite = 0;
	logic [1:0]        cfgIndex = 2'h0;
	logic [15:0]       txData = 16'h0000;
	logic [15:0]       dmaData = 16'h0000;
	sq_pkg::sq_mode_t  modeIn = '0;
	sq_pkg::sq_cscfg_t cfgIn = '0;
	logic              miso, sck, mosi, enabled, emptyFlag, rxFull, dmaReady;
	logic [3:0]        sel_n;
	logic              selInN = 1, modeFault, misoOeN;
	logic [15:0]       rxData, slvWord;
	int                err_total = 0;
	int                compares = 0;
	int                sckFalls = 0;

	always #5 clk = ~clk;

	// slave clock and data stay idle; the select input is pulsed for faults
	sq_spi_unit dut (.clk(clk), .arst_n(arst_n), .enableSet(enSet),
		.enableClear(enClr), .soft_reset_bit(softReset),
		.modeWrite(modeWrite), .modeIn(modeIn), .cfgWrite(cfgWrite),
		.cfgIndex(cfgIndex), .cfgIn(cfgIn), .txWrite(txWrite),
		.txData(txData), .dmaWrite(dmaWrite), .dmaData(dmaData),
		.rxRead(rxRead), .miso(miso), .mosiIn(1'b0), .sckIn(1'b1),
		.selIn_n(selInN), .sck(sck), .mosi(mosi), .sel_n(sel_n),
		.misoOut(), .misoOe_n(misoOeN), .enabled(enabled),
		.tx_holding_empty_flag(emptyFlag), .rxFull(rxFull),
		.rxData(rxData), .modeFault(modeFault), .dmaReady(dmaReady));

	sq_slave_model slave (.sck(sck), .mosi(mosi), .selN(sel_n[0]),
		.miso(miso), .rxWord(slvWord));

	always @(negedge sck) sckFalls++;

	// ****************************************
	// access tasks
	// ****************************************
	task automatic chk(input string what, input logic [15:0] exp, got);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	// k: 0 enable, 1 disable, 2 soft reset, 3 receive read
	task automatic strobe(input int k);
		@(negedge clk);
		{rxRead, softReset, enClr, enSet} = 4'h1 << k;
		@(negedge clk);
		{rxRead, softReset, enClr, enSet} = 4'h0;
	endtask

	// k: 0 software write, 1 dma write
	task automatic wr(input int k, input logic [15:0] d);
		@(negedge clk);
		txData = d;
		dmaData = d;
		{dmaWrite, txWrite} = 2'h1 << k;
		@(negedge clk);
		{dmaWrite, txWrite} = 2'h0;
	endtask

	task automatic setMode(input logic m, f);
		@(negedge clk);
		modeIn = '{m, f, 2'h0};
		modeWrite = 1;
		@(negedge clk);
		modeWrite = 0;
	endtask

	task automatic setCfg(input logic [1:0] i, input sq_pkg::sq_cscfg_t c);
		@(negedge clk);
		cfgIndex = i;
		cfgIn = c;
		cfgWrite = 1;
		@(negedge clk);
		cfgWrite = 0;
	endtask

	// bounded wait: a word takes well under 300 cycles at divider 2
	task automatic waitRx;
		int n;
		n = 0;
		while (rxFull !== 1'b1 && n < 300) begin
			@(negedge clk);
			n++;
		end
		chk("rxFull", 16'h1, {15'h0, rxFull});
	endtask

	task automatic xfer(input logic [15:0] d, input int falls);
		repeat (4) @(negedge clk);
		sckFalls = 0;
		wr(0, d);
		waitRx;
		repeat (4) @(negedge clk);
		chk("sck falls", falls[15:0], sckFalls[15:0]);
		strobe(3);
	endtask

	task automatic stop_test;
		$display("errors=%0d compares=%0d", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ****************************************
	// test sequence and watchdog
	// ****************************************
	initial begin
		#100us;
		err_total++;
		stop_test;
	end

	initial begin
		repeat (3) @(posedge clk);
		@(negedge clk);
		arst_n = 1;
		chk("empty", 16'h1, {15'h0, emptyFlag});
		wr(0, 16'h1234);
		wr(1, 16'h5678);
		repeat (4) @(negedge clk);
		chk("empty", 16'h1, {15'h0, emptyFlag});
		chk("sel_n", 16'hf, {12'h0, sel_n});
		chk("dmaReady", 16'h1, {15'h0, dmaReady});
		strobe(0);
		setMode(1, 1);
		setCfg(0, '{1'b0, 1'b1, 1'b0, 8'h02});
		wr(1, 16'h9c35);
		waitRx;
		chk("slave word", 16'h9c35, slvWord);
		chk("rxData", 16'ha5c3, rxData);
		strobe(3);
		setCfg(0, '{1'b0, 1'b1, 1'b1, 8'h02});
		setMode(1, 0);
		wr(0, 16'h0ff1);
		repeat (80) @(negedge clk);
		chk("sel_n", 16'hf, {12'h0, sel_n});
		chk("empty", 16'h0, {15'h0, emptyFlag});
		strobe(1);
		chk("enabled", 16'h0, {15'h0, enabled});
		chk("empty", 16'h0, {15'h0, emptyFlag});
		strobe(0);
		setMode(1, 1);
		waitRx;
		chk("slave word", 16'h0ff1, slvWord);
		strobe(3);
		setCfg(0, '{1'b1, 1'b0, 1'b0, 8'h02});
		setCfg(1, '{1'b1, 1'b0, 1'b0, 8'h01});
		xfer(16'h00aa, 17);
		setCfg(0, '{1'b1, 1'b0, 1'b0, 8'h01});
		xfer(16'h00aa, 16);
		// select input low in master mode is a fault only while detecting
		setMode(1, 0);
		selInN = 0;
		@(negedge clk);
		selInN = 1;
		chk("modeFault", 16'h1, {15'h0, modeFault});
		setMode(1, 1);
		selInN = 0;
		@(negedge clk);
		selInN = 1;
		chk("modeFault", 16'h0, {15'h0, modeFault});
		setMode(0, 1);
		selInN = 0;
		strobe(1);
		chk("enabled", 16'h1, {15'h0, enabled});
		chk("misoOe_n", 16'h0, {15'h0, misoOeN});
		strobe(3);
		strobe(2);
		chk("enabled", 16'h0, {15'h0, enabled});
		chk("misoOe_n", 16'h1, {15'h0, misoOeN});
		selInN = 1;
		chk("empty", 16'h1, {15'h0, emptyFlag});
		chk("sel_n", 16'hf, {12'h0, sel_n});
		stop_test;
	end
endmodule
